//--- pmcw_ctrl.sv
// Purpose: Operating mode, clock select and wake-up control with its flags
// Assumes: All inputs synchronous to sys_clk; event inputs are 1-cycle pulses
// Notes: Oscillators themselves are outside; this drives their enables
`timescale 1ns/1ps

// Contract
// - Timer 1 underflow sets its flag; request needs its enable and global.
// - Watchdog timeout in interrupt mode sets its flag; enable plus global.
// - Enabled input pins 0..5 changing level set the port change flag.
// - External interrupt select removes pin 0 from level change detection.
// - Chosen edge on pin 0 sets external flag when external select is on.
// - System clock is high oscillator when select is 1, else low.
// - Instruction clock is system clock divided by 2 or 4 by strap.
// - After reset, start normal or slow according to startup clock strap.
// - Writing select 0 goes slow, 1 back to normal; low osc keeps running.
// - Low oscillator clocks timer 0 when routing bit and source strap set.
// - High oscillator stops only by its stop bit or in halt, not by slow or standby.
// - Mode field 10b enters standby, 01b enters halt.
// - Standby stops execution and peripherals; timers follow run bits.
// - Standby wakes on timer0, timer1, watchdog, port change or edge.
// - After wake, resume normal if select is 1, otherwise slow.
// - Halt entry clears power-down flag, sets timeout flag, clears watchdog.
// - Halt stops execution, all peripherals and both oscillators.
// - Halt wakes only on watchdog, port change or external edge.
// - Halt wake waits 16 clocks; standby wake resumes at once.
// - Global enable set before sleep branches to vector after wake.
// - Hardware flags stay set until firmware writes 0 to them.
// - Taken interrupt vectors to 0x008 and clears global enable.
module pmcw_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Configuration straps
  input wire logic cfg_startup_high,
  input wire logic cfg_inst_div4,
  input wire logic cfg_t0_src_low,
  input wire logic cfg_wdt_irq,
  // Event sources
  input wire logic timer0_ovf,
  input wire logic timer1_unf,
  input wire logic wdt_timeout,
  input wire logic [5:0] pin_in,
  input wire logic [5:0] pin_is_input,
  // Clock and power outputs
  output logic high_osc_en,
  output logic low_osc_en,
  output logic sys_clk_sel_high,
  output logic inst_clk_tick,
  output logic timer0_clk_low,
  output logic timer0_en,
  output logic timer1_en,
  output logic periph_en,
  output logic cpu_run,
  output logic wdt_clear,
  // Interrupt hand-off to the core
  output logic irq_req,
  output logic vector_take,
  output logic [9:0] isr_vector
);
  pmcw_pkg::pmcw_state_e state_r, state_nxt;
  logic boot_r;
  logic hsel_r, hstop_r, lck_t0_r;
  logic [1:0] opm_r;
  logic [pmcw_pkg::NSRC-1:0] ien_r, flag_r, flag_nxt, ev;
  logic gie_r;
  logic [5:0] wake_pin_r, pin_prev_r, pin_chg;
  logic eis_r, edge_r, t0run_r, t1run_r;
  logic pd_r, to_r;
  logic [4:0] stab_r;
  logic [1:0] div_r;
  logic ack_r;

  // Bus decode; writes land on the edge where the master sees ack
  wire acc = wb_cyc_i & wb_stb_i;
  wire wr_fire = acc & wb_we_i & ack_r;
  wire wr_b0 = wr_fire & wb_sel_i[0];
  wire wr_b1 = wr_fire & wb_sel_i[1];
  wire hit_osc = wb_adr_i == pmcw_pkg::OFS_OSC_CTRL;
  wire hit_ien = wb_adr_i == pmcw_pkg::OFS_INT_EN;
  wire hit_flag = wb_adr_i == pmcw_pkg::OFS_INT_FLAG;
  wire hit_port = wb_adr_i == pmcw_pkg::OFS_PORT_CTRL;
  wire hit_stat = wb_adr_i == pmcw_pkg::OFS_STATUS;
  wire hit_cmd = wb_adr_i == pmcw_pkg::OFS_CMD;
  wire wr_osc = wr_b0 & hit_osc;
  wire [1:0] opm_wr = wb_dat_i[pmcw_pkg::OSC_MODE_LSB +: 2];
  wire sleep_cmd = wr_b0 & hit_cmd & wb_dat_i[pmcw_pkg::CMD_SLEEP_BIT];

  // Mode entry requests; only taken while the core is running
  wire running = state_r == pmcw_pkg::ST_RUN;
  wire halt_go = running & ((wr_osc & opm_wr == pmcw_pkg::OPM_HALT)
    | sleep_cmd);
  wire stby_go = running & ~halt_go & wr_osc
    & opm_wr == pmcw_pkg::OPM_STANDBY;

  // Per-pin change detect; pin 0 yields to the external edge input
  generate
    for (genvar i = 0; i < 6; i++)
    begin : g_pin
      if (i == 0)
      begin : g_p0
        assign pin_chg[i] = (pin_in[i] ^ pin_prev_r[i]) & pin_is_input[i]
          & wake_pin_r[i] & ~eis_r;
      end
      else
      begin : g_pn
        assign pin_chg[i] = (pin_in[i] ^ pin_prev_r[i]) & pin_is_input[i]
          & wake_pin_r[i];
      end
    end
  endgenerate

  // External edge on pin 0: edge bit 1 picks rising, 0 falling
  wire ext_edge = eis_r & (edge_r ? (pin_in[0] & ~pin_prev_r[0])
    : (~pin_in[0] & pin_prev_r[0]));

  // Timers are gated in halt, so their events cannot arrive there
  wire in_halt = state_r == pmcw_pkg::ST_HALT
    | state_r == pmcw_pkg::ST_STAB;
  assign ev[pmcw_pkg::SRC_T0] = timer0_ovf & ~in_halt;
  assign ev[pmcw_pkg::SRC_T1] = timer1_unf & ~in_halt;
  assign ev[pmcw_pkg::SRC_WDT] = wdt_timeout & cfg_wdt_irq;
  assign ev[pmcw_pkg::SRC_PORT] = |pin_chg;
  assign ev[pmcw_pkg::SRC_EXT] = ext_edge;

  // Sticky flags: writing 0 clears, a new event in that cycle wins
  wire [pmcw_pkg::NSRC-1:0] flag_keep = (wr_b0 & hit_flag)
    ? wb_dat_i[pmcw_pkg::NSRC-1:0] : '1;
  assign flag_nxt = (flag_r & flag_keep) | ev;

  // Wake sources by mode; the global enable is not consulted here
  wire [pmcw_pkg::NSRC-1:0] pend = flag_r & ien_r;
  localparam logic [pmcw_pkg::NSRC-1:0] HALT_SRC_MASK =
    5'h1C; // Watchdog, port change and external edge only
  wire wake_stby = |pend;
  wire wake_halt = |(pend & HALT_SRC_MASK);
  wire stab_done = stab_r == 5'h01;

  // Interrupt taken while running, or on resuming with global enable set
  wire resume = (state_r == pmcw_pkg::ST_STBY & wake_stby)
    | (state_r == pmcw_pkg::ST_STAB & stab_done);
  wire take = gie_r & |pend & (running | resume);

  // Next-state logic for the operating mode
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      pmcw_pkg::ST_RUN:
      begin
        if (halt_go)
          state_nxt = pmcw_pkg::ST_HALT;
        else if (stby_go)
          state_nxt = pmcw_pkg::ST_STBY;
      end
      pmcw_pkg::ST_STBY:
      begin
        if (wake_stby)
          state_nxt = pmcw_pkg::ST_RUN;
      end
      pmcw_pkg::ST_HALT:
      begin
        if (wake_halt)
          state_nxt = pmcw_pkg::ST_STAB;
      end
      pmcw_pkg::ST_STAB:
      begin
        if (stab_done)
          state_nxt = pmcw_pkg::ST_RUN;
      end
      default: state_nxt = pmcw_pkg::ST_RUN;
    endcase
  end

  // Output levels follow the next state so they line up with state_r
  wire nxt_run = state_nxt == pmcw_pkg::ST_RUN;
  wire nxt_halt = state_nxt == pmcw_pkg::ST_HALT;
  wire nxt_stab = state_nxt == pmcw_pkg::ST_STAB;
  wire nxt_sleep = ~nxt_run;
  wire hsel_nxt = boot_r ? cfg_startup_high
    : (wr_osc ? wb_dat_i[pmcw_pkg::OSC_HSEL_BIT] : hsel_r);
  wire hstop_nxt = wr_osc ? wb_dat_i[pmcw_pkg::OSC_HSTOP_BIT] : hstop_r;
  // High osc keeps going in slow and standby unless its stop bit is set
  wire hosc_nxt = ~hstop_nxt & ~nxt_halt;
  wire losc_nxt = ~nxt_halt;

  // Mode code reported in status; sleep states stand above the selection
  wire [1:0] mode_code = (state_r == pmcw_pkg::ST_STBY)
    ? pmcw_pkg::MODE_STANDBY : in_halt ? pmcw_pkg::MODE_HALT
    : (hsel_r ? pmcw_pkg::MODE_NORMAL : pmcw_pkg::MODE_SLOW);

  // Read mux; unmapped offsets read as zero
  logic [31:0] rd_data;
  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (hit_osc)
    begin
      rd_data[pmcw_pkg::OSC_HSEL_BIT] = hsel_r;
      rd_data[pmcw_pkg::OSC_HSTOP_BIT] = hstop_r;
      rd_data[pmcw_pkg::OSC_MODE_LSB +: 2] = opm_r;
      rd_data[pmcw_pkg::OSC_LCK_T0_BIT] = lck_t0_r;
    end
    else if (hit_ien)
    begin
      rd_data[pmcw_pkg::NSRC-1:0] = ien_r;
      rd_data[pmcw_pkg::GIE_BIT] = gie_r;
    end
    else if (hit_flag)
      rd_data[pmcw_pkg::NSRC-1:0] = flag_r;
    else if (hit_port)
    begin
      rd_data[5:0] = wake_pin_r;
      rd_data[pmcw_pkg::PC_EIS_BIT] = eis_r;
      rd_data[pmcw_pkg::PC_EDGE_BIT] = edge_r;
      rd_data[pmcw_pkg::PC_T0RUN_BIT] = t0run_r;
      rd_data[pmcw_pkg::PC_T1RUN_BIT] = t1run_r;
    end
    else if (hit_stat)
    begin
      rd_data[pmcw_pkg::ST_MODE_LSB +: 2] = mode_code;
      rd_data[pmcw_pkg::ST_PD_BIT] = pd_r;
      rd_data[pmcw_pkg::ST_TO_BIT] = to_r;
    end
  end

  // Bus slave: one wait state, ack drops the cycle after it is given
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ack_r <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_r <= acc & ~ack_r;
      wb_ack_o <= acc & ~ack_r;
      wb_dat_o <= rd_data;
    end
  end

  // Strap capture happens in the first clock after reset release
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      boot_r <= 1'b1;
      hsel_r <= 1'b1;
      hstop_r <= 1'b0;
      lck_t0_r <= 1'b0;
      opm_r <= pmcw_pkg::OPM_NONE;
    end
    else
    begin
      boot_r <= 1'b0;
      hsel_r <= hsel_nxt;
      hstop_r <= hstop_nxt;
      if (wr_osc)
        lck_t0_r <= wb_dat_i[pmcw_pkg::OSC_LCK_T0_BIT];
      // Mode field reads back while asleep and clears on wake
      if (halt_go)
        opm_r <= pmcw_pkg::OPM_HALT;
      else if (stby_go)
        opm_r <= pmcw_pkg::OPM_STANDBY;
      else if (nxt_run)
        opm_r <= pmcw_pkg::OPM_NONE;
    end
  end

  // Enables, port control and flags
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      ien_r <= '0;
      gie_r <= 1'b0;
      flag_r <= '0;
      wake_pin_r <= 6'h00;
      eis_r <= 1'b0;
      edge_r <= 1'b0;
      t0run_r <= 1'b0;
      t1run_r <= 1'b0;
      pin_prev_r <= 6'h00;
    end
    else
    begin
      if (wr_b0 & hit_ien)
        ien_r <= wb_dat_i[pmcw_pkg::NSRC-1:0];
      if (take)
        gie_r <= 1'b0;
      else if (wr_b0 & hit_ien)
        gie_r <= wb_dat_i[pmcw_pkg::GIE_BIT];
      flag_r <= flag_nxt;
      if (wr_b0 & hit_port)
        wake_pin_r <= wb_dat_i[5:0];
      if (wr_b1 & hit_port)
      begin
        eis_r <= wb_dat_i[pmcw_pkg::PC_EIS_BIT];
        edge_r <= wb_dat_i[pmcw_pkg::PC_EDGE_BIT];
        t0run_r <= wb_dat_i[pmcw_pkg::PC_T0RUN_BIT];
        t1run_r <= wb_dat_i[pmcw_pkg::PC_T1RUN_BIT];
      end
      pin_prev_r <= pin_in;
    end
  end

  // Status flags; a watchdog timeout clears the timeout flag
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      pd_r <= pmcw_pkg::RST_PD;
      to_r <= pmcw_pkg::RST_TO;
      state_r <= pmcw_pkg::ST_RUN;
      stab_r <= 5'h00;
    end
    else
    begin
      if (halt_go)
      begin
        pd_r <= 1'b0;
        to_r <= 1'b1;
      end
      else if (wdt_timeout)
        to_r <= 1'b0;
      state_r <= state_nxt;
      if (state_r == pmcw_pkg::ST_HALT & wake_halt)
        stab_r <= pmcw_pkg::WAKE_STAB_CNT;
      else if (stab_r != 5'h00)
        stab_r <= stab_r - 5'h01;
    end
  end

  // Instruction clock divider, free running off the selected clock
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      div_r <= 2'h0;
      inst_clk_tick <= 1'b0;
    end
    else
    begin
      div_r <= (cfg_inst_div4 | div_r[0] == 1'b0) ? div_r + 2'h1 : 2'h0;
      inst_clk_tick <= cfg_inst_div4 ? (div_r == 2'h3)
        : div_r[0];
    end
  end

  // Registered clock and power outputs
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      high_osc_en <= 1'b1;
      low_osc_en <= 1'b1;
      sys_clk_sel_high <= 1'b1;
      timer0_clk_low <= 1'b0;
      timer0_en <= 1'b0;
      timer1_en <= 1'b0;
      periph_en <= 1'b1;
      cpu_run <= 1'b1;
      wdt_clear <= 1'b0;
      irq_req <= 1'b0;
      vector_take <= 1'b0;
      isr_vector <= pmcw_pkg::ISR_VECTOR;
    end
    else
    begin
      high_osc_en <= hosc_nxt;
      low_osc_en <= losc_nxt;
      sys_clk_sel_high <= hsel_nxt;
      timer0_clk_low <= lck_t0_r & cfg_t0_src_low;
      // Timers keep counting in standby, but not in halt
      timer0_en <= t0run_r & ~nxt_halt & ~nxt_stab;
      timer1_en <= t1run_r & ~nxt_halt & ~nxt_stab;
      periph_en <= ~nxt_sleep;
      cpu_run <= nxt_run;
      wdt_clear <= halt_go;
      irq_req <= gie_r & |pend;
      vector_take <= take;
      isr_vector <= pmcw_pkg::ISR_VECTOR;
    end
  end

  // Checks
  sequence s_halt_wake;
    state_r == pmcw_pkg::ST_HALT && wake_halt;
  endsequence
  sequence s_held_asleep;
    !cpu_run [*8];
  endsequence

  a_t1_flag_set: assert property (
    @(posedge sys_clk) disable iff (rst)
    timer1_unf && !in_halt |=> flag_r[pmcw_pkg::SRC_T1])
    else $error("timer 1 underflow did not set its flag");
  a_wdt_flag_set: assert property (
    @(posedge sys_clk) disable iff (rst)
    wdt_timeout && cfg_wdt_irq |=> flag_r[pmcw_pkg::SRC_WDT])
    else $error("watchdog timeout did not set its flag");
  a_pin0_masked: assert property (
    @(posedge sys_clk) disable iff (rst)
    eis_r |-> !pin_chg[0])
    else $error("pin 0 change seen while external select on");
  a_flag_sticky: assert property (
    @(posedge sys_clk) disable iff (rst)
    flag_r[pmcw_pkg::SRC_PORT] && !(wr_b0 && hit_flag)
    |=> flag_r[pmcw_pkg::SRC_PORT])
    else $error("port change flag dropped without a clear");
  a_halt_entry_flags: assert property (
    @(posedge sys_clk) disable iff (rst)
    halt_go |=> !pd_r && to_r && wdt_clear)
    else $error("halt entry status or watchdog clear wrong");
  a_halt_osc_off: assert property (
    @(posedge sys_clk) disable iff (rst)
    halt_go |=> !high_osc_en && !low_osc_en && !cpu_run)
    else $error("oscillators or core still on in halt");
  a_halt_stab_wait: assert property (
    @(posedge sys_clk) disable iff (rst)
    s_halt_wake |=> s_held_asleep ##8 !cpu_run ##[1:2] cpu_run)
    else $error("halt wake stabilisation length wrong");
  a_stby_no_wait: assert property (
    @(posedge sys_clk) disable iff (rst)
    state_r == pmcw_pkg::ST_STBY && wake_stby |=> cpu_run)
    else $error("standby wake was delayed");
  a_halt_wake_src: assert property (
    @(posedge sys_clk) disable iff (rst)
    state_r == pmcw_pkg::ST_HALT && !wake_halt
    |=> state_r == pmcw_pkg::ST_HALT)
    else $error("halt left without a halt wake source");
  a_vector_gie_clr: assert property (
    @(posedge sys_clk) disable iff (rst)
    $rose(vector_take) |-> !gie_r && isr_vector == pmcw_pkg::ISR_VECTOR)
    else $error("vector taken but global enable still set");
  a_clk_sel_follow: assert property (
    @(posedge sys_clk) disable iff (rst)
    wr_osc && !boot_r
    |=> sys_clk_sel_high == $past(wb_dat_i[pmcw_pkg::OSC_HSEL_BIT]))
    else $error("system clock select did not follow write");
endmodule : pmcw_ctrl

//--- pmcw_pkg.sv
// Purpose: Shared constants for the power mode, clock and wake-up controller
// Assumes: Registers sit on a classic Wishbone slave, 32-bit data words
// Notes: Every figure used by the controller, except its halt wake source mask, pin count and divider and counter limits, is named here once
package pmcw_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_OSC_CTRL = 8'h00;
  localparam logic [7:0] OFS_INT_EN = 8'h04;
  localparam logic [7:0] OFS_INT_FLAG = 8'h08;
  localparam logic [7:0] OFS_PORT_CTRL = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_CMD = 8'h14;
  // osc_ctrl fields
  localparam int OSC_HSEL_BIT = 0;
  localparam int OSC_HSTOP_BIT = 1;
  localparam int OSC_MODE_LSB = 2;
  localparam int OSC_LCK_T0_BIT = 4;
  // Interrupt source bit positions (enable and flag registers)
  localparam int SRC_T0 = 0;
  localparam int SRC_T1 = 1;
  localparam int SRC_WDT = 2;
  localparam int SRC_PORT = 3;
  localparam int SRC_EXT = 4;
  localparam int NSRC = 5;
  localparam int GIE_BIT = 7;
  // port_ctrl fields
  localparam int PC_EIS_BIT = 8;
  localparam int PC_EDGE_BIT = 9;
  localparam int PC_T0RUN_BIT = 12;
  localparam int PC_T1RUN_BIT = 13;
  // status fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_PD_BIT = 3;
  localparam int ST_TO_BIT = 4;
  // cmd fields
  localparam int CMD_SLEEP_BIT = 0;
  // op_mode_sel encodings
  localparam logic [1:0] OPM_NONE = 2'h0;
  localparam logic [1:0] OPM_HALT = 2'h1;
  localparam logic [1:0] OPM_STANDBY = 2'h2;
  // Reported mode codes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SLOW = 2'h1;
  localparam logic [1:0] MODE_STANDBY = 2'h2;
  localparam logic [1:0] MODE_HALT = 2'h3;
  // Reset values
  localparam logic RST_PD = 1'b1;
  localparam logic RST_TO = 1'b1;
  localparam logic [9:0] ISR_VECTOR = 10'h008;
  // Halt wake-up stabilisation, in system clock cycles
  localparam int WAKE_STAB_CYC = 16;
  localparam logic [4:0] WAKE_STAB_CNT = 5'(WAKE_STAB_CYC);
  // Controller states
  typedef enum logic [1:0] {ST_RUN, ST_STBY, ST_HALT, ST_STAB} pmcw_state_e;
endpackage : pmcw_pkg

//--- pmcw_tb.sv
// Purpose: Self-checking bench for the power mode and wake-up controller
// Assumes: Classic Wishbone single cycles; events are one-cycle pulses
// Notes: Outputs are read at the rising edge, before that edge lands
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] A_OSC = pmcw_pkg::OFS_OSC_CTRL;
  localparam logic [7:0] A_EN = pmcw_pkg::OFS_INT_EN;
  localparam logic [7:0] A_FLG = pmcw_pkg::OFS_INT_FLAG;
  localparam logic [7:0] A_PC = pmcw_pkg::OFS_PORT_CTRL;
  localparam logic [7:0] A_ST = pmcw_pkg::OFS_STATUS;
  // Design inputs, all valued at time zero
  logic sys_clk = 0, rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic cfg_startup_high = 1, cfg_inst_div4 = 0, cfg_t0_src_low = 0;
  logic cfg_wdt_irq = 1, timer0_ovf = 0, timer1_unf = 0, wdt_timeout = 0;
  logic [5:0] pin_in = 6'h00, pin_is_input = 6'h3f;
  // Design outputs
  logic [31:0] wb_dat_o;
  logic wb_ack_o, high_osc_en, low_osc_en, sys_clk_sel_high, inst_clk_tick;
  logic timer0_clk_low, timer0_en, timer1_en, periph_en, cpu_run;
  logic wdt_clear, irq_req, vector_take;
  logic [9:0] isr_vector;
  int err_count = 0, total_checks = 0, cyc_cnt = 0, vec_cnt = 0, wclr_cnt = 0;
  integer seed = 32'hb28c;

  pmcw_ctrl DUT (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .cfg_startup_high,
    .cfg_inst_div4, .cfg_t0_src_low, .cfg_wdt_irq, .timer0_ovf, .timer1_unf,
    .wdt_timeout, .pin_in, .pin_is_input, .high_osc_en, .low_osc_en,
    .sys_clk_sel_high, .inst_clk_tick, .timer0_clk_low, .timer0_en,
    .timer1_en, .periph_en, .cpu_run, .wdt_clear, .irq_req, .vector_take,
    .isr_vector);

  // Clock at 200 MHz
  initial
  begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Pulse monitors and hang guard; pulses may fall inside a bus task
  always @(posedge sys_clk)
  begin
    cyc_cnt++;
    if (vector_take === 1'b1) vec_cnt++;
    if (wdt_clear === 1'b1) wclr_cnt++;
    if (cyc_cnt == 20000)
    begin
      err_count++;
      summarize();
    end
  end

  function automatic logic [31:0] bv(input int i);
    return 32'h0000_0001 << i;
  endfunction : bv

  function automatic logic [1:0] exp_mode(input logic sel);
    return sel ? pmcw_pkg::MODE_NORMAL : pmcw_pkg::MODE_SLOW;
  endfunction : exp_mode

  function automatic int exp_ticks(input logic d4, input int n);
    return d4 ? n / 4 : n / 2;
  endfunction : exp_ticks

  task automatic summarize();
    if (err_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      err_count++;
    end
  endtask : chk

  // One classic cycle; held until ack, then one idle cycle
  task automatic xfer(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    chk(n, 2, "bus ack latency");
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge sys_clk);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0000_0000, q);
  endtask : rd

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // Bounded wait for execution to resume, returns cycles waited
  task automatic wait_run(output int n);
    n = 0;
    while (cpu_run !== 1'b1 && n < 40)
    begin
      @(posedge sys_clk);
      n++;
    end
  endtask : wait_run

  // Main sequence
  initial
  begin
    logic [31:0] q;
    int n, k, v0, w0;
    logic s, e;
    for (int p = 0; p < 2; p++)
    begin
      rst <= 1'b1;
      cfg_startup_high <= p[0];
      cfg_inst_div4 <= 1'($random(seed));
      cfg_t0_src_low <= 1'($random(seed));
      tick(3);
      rst <= 1'b0;
      tick(2);
      chk(sys_clk_sel_high, p[0], "startup clock");
      rd(A_ST, q);
      chk(q[4:0], {2'b11, 1'b0, exp_mode(p[0])}, "reset status");
      chk(isr_vector, pmcw_pkg::ISR_VECTOR, "vector");
      n = 0;
      repeat (40)
      begin
        @(posedge sys_clk);
        if (inst_clk_tick === 1'b1) n++;
      end
      chk(n, exp_ticks(cfg_inst_div4, 40), "instruction ticks");
    end
    // Slow, stop, back to normal with timer 0 on the low clock
    wr(A_OSC, 32'h0000_0000);
    tick(2);
    chk({sys_clk_sel_high, high_osc_en, low_osc_en}, 3'b011, "slow");
    wr(A_OSC, bv(pmcw_pkg::OSC_HSTOP_BIT));
    tick(2);
    chk(high_osc_en, 1'b0, "high osc stop");
    wr(A_OSC, bv(pmcw_pkg::OSC_HSEL_BIT) | bv(pmcw_pkg::OSC_LCK_T0_BIT));
    tick(2);
    chk({sys_clk_sel_high, high_osc_en}, 2'b11, "normal");
    chk(timer0_clk_low, cfg_t0_src_low, "timer0 low clock");
    // Timer 1 flag, request, vector and clear
    wr(A_EN, bv(pmcw_pkg::SRC_T1));
    timer1_unf <= 1'b1;
    @(posedge sys_clk);
    timer1_unf <= 1'b0;
    tick(8);
    rd(A_FLG, q);
    chk(q[pmcw_pkg::SRC_T1], 1'b1, "t1 flag sticks");
    chk(irq_req, 1'b0, "no request without global");
    v0 = vec_cnt;
    wr(A_EN, bv(pmcw_pkg::SRC_T1) | bv(pmcw_pkg::GIE_BIT));
    @(posedge sys_clk);
    chk(irq_req, 1'b1, "request with global");
    tick(5);
    chk(vec_cnt, v0 + 1, "t1 vector");
    rd(A_EN, q);
    chk(q[pmcw_pkg::GIE_BIT], 1'b0, "global cleared");
    wr(A_FLG, ~bv(pmcw_pkg::SRC_T1));
    rd(A_FLG, q);
    chk(q[pmcw_pkg::SRC_T1], 1'b0, "t1 flag cleared");
    // Watchdog interrupt flag
    wdt_timeout <= 1'b1;
    @(posedge sys_clk);
    wdt_timeout <= 1'b0;
    tick(2);
    rd(A_FLG, q);
    chk(q[pmcw_pkg::SRC_WDT], 1'b1, "wdt flag");
    // Port change on a random pin, output pin ignored
    k = 1 + ($unsigned($random(seed)) % 5);
    wr(A_FLG, 32'h0000_0000);
    wr(A_PC, 32'h0000_003f);
    pin_in[k] <= ~pin_in[k];
    tick(3);
    rd(A_FLG, q);
    chk(q[pmcw_pkg::SRC_PORT], 1'b1, "port change");
    wr(A_FLG, 32'h0000_0000);
    pin_is_input[k] <= 1'b0;
    @(posedge sys_clk);
    pin_in[k] <= ~pin_in[k];
    tick(3);
    rd(A_FLG, q);
    chk(q[pmcw_pkg::SRC_PORT], 1'b0, "output pin");
    pin_is_input[k] <= 1'b1;
    // External edge on pin 0 with random polarity
    e = 1'($random(seed));
    wr(A_PC, 32'h0000_003f | bv(pmcw_pkg::PC_EIS_BIT) | ({31'h0, e} << 9));
    pin_in[0] <= ~e;
    tick(3);
    wr(A_FLG, 32'h0000_0000);
    pin_in[0] <= e;
    tick(3);
    rd(A_FLG, q);
    chk(q[pmcw_pkg::SRC_EXT], 1'b1, "ext edge");
    chk(q[pmcw_pkg::SRC_PORT], 1'b0, "pin0 masked");
    wr(A_FLG, 32'h0000_0000);
    // Standby, woken by timer 0 with timers kept running
    s = 1'($random(seed));
    wr(A_PC, 32'h0000_303f | bv(pmcw_pkg::PC_EIS_BIT));
    wr(A_EN, bv(pmcw_pkg::SRC_T0));
    wr(A_OSC, {31'h0, s});
    v0 = vec_cnt;
    wr(A_OSC, {31'h0, s} | {28'h0, pmcw_pkg::OPM_STANDBY, 2'b00});
    tick(2);
    chk({cpu_run, periph_en, timer0_en, timer1_en, low_osc_en}, 5'b00111,
        "standby outputs");
    rd(A_ST, q);
    chk(q[1:0], pmcw_pkg::MODE_STANDBY, "standby mode");
    timer0_ovf <= 1'b1;
    @(posedge sys_clk);
    timer0_ovf <= 1'b0;
    wait_run(n);
    chk(n < 5, 1'b1, "standby wake");
    rd(A_ST, q);
    chk(q[1:0], exp_mode(s), "resume mode");
    rd(A_OSC, q);
    chk(q[3:2], pmcw_pkg::OPM_NONE, "mode field");
    chk(vec_cnt, v0, "no vector");
    // Halt by sleep command with global enable; timer 1 must not wake
    wr(A_FLG, 32'h0000_0000);
    wr(A_EN, bv(pmcw_pkg::SRC_T1) | bv(pmcw_pkg::SRC_WDT) |
        bv(pmcw_pkg::GIE_BIT));
    w0 = wclr_cnt;
    wr(pmcw_pkg::OFS_CMD, bv(pmcw_pkg::CMD_SLEEP_BIT));
    chk({cpu_run, periph_en, timer0_en, high_osc_en, low_osc_en}, 5'b00000,
        "halt outputs");
    rd(A_ST, q);
    chk(q[4:0], {2'b10, 1'b0, pmcw_pkg::MODE_HALT}, "halt status");
    chk(wclr_cnt, w0 + 1, "wdt cleared");
    timer1_unf <= 1'b1;
    @(posedge sys_clk);
    timer1_unf <= 1'b0;
    tick(6);
    chk(cpu_run, 1'b0, "timer ignored in halt");
    v0 = vec_cnt;
    wdt_timeout <= 1'b1;
    @(posedge sys_clk);
    wdt_timeout <= 1'b0;
    wait_run(n);
    chk(n >= 16 && n < 25, 1'b1, "halt stabilising");
    tick(3);
    chk(vec_cnt, v0 + 1, "vector after wake");
    rd(A_ST, q);
    chk(q[1:0], exp_mode(s), "halt resume mode");
    // Halt by mode field, port wake with global enable off
    wr(A_FLG, 32'h0000_0000);
    wr(A_EN, bv(pmcw_pkg::SRC_PORT));
    v0 = vec_cnt;
    wr(A_OSC, {31'h0, s} | {28'h0, pmcw_pkg::OPM_HALT, 2'b00});
    rd(A_ST, q);
    chk(q[1:0], pmcw_pkg::MODE_HALT, "halt by field");
    pin_in[k] <= ~pin_in[k];
    @(posedge sys_clk);
    wait_run(n);
    tick(3);
    chk({cpu_run, vec_cnt == v0}, 2'b11, "wake without global");
    summarize();
  end
endmodule : testbench
